// >>> design/ospt_pkg.sv
// Package: register map, field layout and crystal translation table
package ospt_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_RCC    = 12'h060;
  localparam logic [11:0] OFS_PLL_TRANSLATION_VALUES = 12'h064;

  // Run-mode clock configuration field positions
  localparam int MAIN_OSCILLATOR_DIS_BIT  = 0;
  localparam int INTERNAL_OSCILLATOR_DIS_BIT  = 1;
  localparam int OSC_SRC_LSB   = 4;
  localparam int OSC_SRC_MSB   = 5;
  localparam int CRYSTAL_CODE_LSB      = 6;
  localparam int CRYSTAL_CODE_MSB      = 9;

  // Translation register field positions
  localparam int PLL_R_LSB = 0;
  localparam int PLL_R_MSB = 4;
  localparam int PLL_F_LSB = 5;
  localparam int PLL_F_MSB = 13;

  // Oscillator source encodings
  localparam logic [1:0] OSC_MAIN     = 2'h0;
  localparam logic [1:0] OSC_INT      = 2'h1;
  localparam logic [1:0] OSC_INT_DIV4 = 2'h2;
  localparam logic [1:0] OSC_INT_30K  = 2'h3;

  // Reset values
  localparam logic [1:0] RST_OSC_SRC  = OSC_INT;
  localparam logic       RST_INTERNAL_OSCILLATOR_DIS = 1'h0;
  localparam logic       RST_MAIN_OSCILLATOR_DIS = 1'h1;
  localparam logic [3:0] RST_CRYSTAL_CODE     = 4'hb;

  // Bus constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Crystal code to {F, R}; aims the PLL near 400 MHz, F+2 = 400*(R+1)/crystal frequency in MHz
  function automatic logic [13:0] crystal_code_to_pll(input logic [3:0] code);
    logic [13:0] fr;
    fr = 14'h0;
    unique case (code)
      4'h0: fr = {9'h18e, 5'h00};
      4'h1: fr = {9'h0d7, 5'h00};
      4'h2: fr = {9'h0c6, 5'h00};
      4'h3: fr = {9'h0a1, 5'h00};
      4'h4: fr = {9'h14d, 5'h02};
      4'h5: fr = {9'h143, 5'h02};
      4'h6: fr = {9'h18e, 5'h03};
      4'h7: fr = {9'h184, 5'h03};
      4'h8: fr = {9'h195, 5'h04};
      4'h9: fr = {9'h18e, 5'h04};
      4'ha: fr = {9'h184, 5'h04};
      4'hb: fr = {9'h18e, 5'h05};
      4'hc: fr = {9'h184, 5'h05};
      4'hd: fr = {9'h17a, 5'h06};
      4'he: fr = {9'h18e, 5'h07};
      4'hf: fr = {9'h184, 5'h07};
    endcase
    return fr;
  endfunction

endpackage

// >>> design/ospt_top.sv
// Oscillator select and crystal to PLL translation, AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ospt_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Oscillator controls
  output logic [1:0]             osc_source,
  output logic                   internal_osc_disable,
  output logic                   main_osc_disable,
  // PLL inputs
  output logic [8:0]             pll_f,
  output logic [4:0]             pll_r
);

  typedef struct packed {
    logic        loaded;
    logic        ph_act;
    logic        ph_write;
    logic        ph_word;
    logic [11:0] ph_addr;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic [3:0]  crystal_code;
    logic [1:0]  osc_src;
    logic        internal_oscillator_dis;
    logic        main_oscillator_dis;
    logic [8:0]  pll_f;
    logic [4:0]  pll_r;
  } ospt_state_s;

  logic [1:0]  rst_sync;
  logic        rst_q;
  ospt_state_s s;
  ospt_state_s next_s;
  logic [13:0] next_fr;
  logic [31:0] rcc_view;
  logic [31:0] pll_view;

  // Reset release through two flops; assert stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'h1};
  end

  assign rst_q = rst_sync[1];

  always_comb
  begin
    rcc_view = 32'h0;
    rcc_view[ospt_pkg::CRYSTAL_CODE_MSB:ospt_pkg::CRYSTAL_CODE_LSB] = s.crystal_code;
    rcc_view[ospt_pkg::OSC_SRC_MSB:ospt_pkg::OSC_SRC_LSB] = s.osc_src;
    rcc_view[ospt_pkg::INTERNAL_OSCILLATOR_DIS_BIT] = s.internal_oscillator_dis;
    rcc_view[ospt_pkg::MAIN_OSCILLATOR_DIS_BIT] = s.main_oscillator_dis;
    pll_view = 32'h0;
    pll_view[ospt_pkg::PLL_F_MSB:ospt_pkg::PLL_F_LSB] = s.pll_f;
    pll_view[ospt_pkg::PLL_R_MSB:ospt_pkg::PLL_R_LSB] = s.pll_r;
  end

  always_comb
  begin
    next_s = s;
    next_fr = 14'h0;

    // First cycle after reset release loads the translation; bus stays
    // stalled until then so no read can see an unloaded value
    if (!s.loaded)
    begin
      next_fr = ospt_pkg::crystal_code_to_pll(s.crystal_code);
      next_s.pll_f = next_fr[13:5];
      next_s.pll_r = next_fr[4:0];
      next_s.loaded = 1'h1;
      next_s.hreadyout = 1'h1;
    end

    // Write data phase completes in its first cycle
    if (s.ph_act && s.ph_write && s.hreadyout && s.ph_word)
    begin
      if (s.ph_addr == ospt_pkg::OFS_RCC)
      begin
        next_s.crystal_code = hwdata[ospt_pkg::CRYSTAL_CODE_MSB:ospt_pkg::CRYSTAL_CODE_LSB];
        next_s.osc_src =
          hwdata[ospt_pkg::OSC_SRC_MSB:ospt_pkg::OSC_SRC_LSB];
        next_s.internal_oscillator_dis = hwdata[ospt_pkg::INTERNAL_OSCILLATOR_DIS_BIT];
        next_s.main_oscillator_dis = hwdata[ospt_pkg::MAIN_OSCILLATOR_DIS_BIT];
      end
      // Translation offset has no write path at all
    end

    // Recompute in the same edge as the write, so a read that follows
    // back to back already sees the new translation
    if (s.loaded && (next_s.crystal_code != s.crystal_code))
    begin
      next_fr = ospt_pkg::crystal_code_to_pll(next_s.crystal_code);
      next_s.pll_f = next_fr[13:5];
      next_s.pll_r = next_fr[4:0];
    end

    // Reads take one wait state so the data comes from a flop
    if (s.ph_act && !s.ph_write && !s.hreadyout)
    begin
      unique case (s.ph_addr)
        ospt_pkg::OFS_RCC:    next_s.hrdata = rcc_view;
        ospt_pkg::OFS_PLL_TRANSLATION_VALUES: next_s.hrdata = pll_view;
        default:              next_s.hrdata = 32'h0;
      endcase
      next_s.hreadyout = 1'h1;
    end

    // New address phase
    if (s.loaded && hready)
    begin
      if (hsel && htrans[1])
      begin
        next_s.ph_act = 1'h1;
        next_s.ph_write = hwrite;
        next_s.ph_word = (hsize == ospt_pkg::HSIZE_WORD);
        next_s.ph_addr = 12'(haddr);
        next_s.hreadyout = hwrite;
      end
      else
      begin
        next_s.ph_act = 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      s <= '0;
      s.crystal_code <= ospt_pkg::RST_CRYSTAL_CODE;
      s.osc_src <= ospt_pkg::RST_OSC_SRC;
      s.internal_oscillator_dis <= ospt_pkg::RST_INTERNAL_OSCILLATOR_DIS;
      s.main_oscillator_dis <= ospt_pkg::RST_MAIN_OSCILLATOR_DIS;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'h0;
  assign hrdata = s.hrdata;
  assign osc_source = s.osc_src;
  assign internal_osc_disable = s.internal_oscillator_dis;
  assign main_osc_disable = s.main_oscillator_dis;
  assign pll_f = s.pll_f;
  assign pll_r = s.pll_r;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_q);

  sequence rd_done(logic [11:0] a);
    s.ph_act && !s.ph_write && !s.hreadyout && (s.ph_addr == a) ##1
      s.hreadyout;
  endsequence

  sequence wr_pll_done;
    s.ph_act && s.ph_write && s.hreadyout &&
      (s.ph_addr == ospt_pkg::OFS_PLL_TRANSLATION_VALUES);
  endsequence

  osc_reset_a: assert property (
    $rose(s.loaded) |-> osc_source == ospt_pkg::OSC_INT)
    else $error("oscillator source not internal after reset");

  internal_oscillator_reset_a: assert property (
    $rose(s.loaded) |-> !internal_osc_disable)
    else $error("internal oscillator off after reset");

  main_oscillator_reset_a: assert property (
    $rose(s.loaded) |-> main_osc_disable)
    else $error("main oscillator on after reset");

  rcc_rsvd_a: assert property (
    rd_done(ospt_pkg::OFS_RCC) |-> (hrdata[3:2] == 2'h0) &&
      (hrdata[31:10] == 22'h0) && (hrdata[9:6] == s.crystal_code))
    else $error("configuration read shows bad reserved or code bits");

  load_seq_a: assert property (
    !s.loaded |-> !hreadyout ##1 (s.loaded && hreadyout &&
      ({pll_f, pll_r} == ospt_pkg::crystal_code_to_pll(s.crystal_code))))
    else $error("translation not loaded at reset release");

  crystal_code_update_a: assert property (
    s.loaded && $changed(s.crystal_code) |->
      {pll_f, pll_r} == ospt_pkg::crystal_code_to_pll(s.crystal_code))
    else $error("translation not updated on crystal change");

  f_field_a: assert property (
    rd_done(ospt_pkg::OFS_PLL_TRANSLATION_VALUES) |-> hrdata[13:5] == pll_f)
    else $error("F field does not match PLL F");

  r_field_a: assert property (
    rd_done(ospt_pkg::OFS_PLL_TRANSLATION_VALUES) |-> hrdata[4:0] == pll_r)
    else $error("R field does not match PLL R");

  pll_rsvd_a: assert property (
    rd_done(ospt_pkg::OFS_PLL_TRANSLATION_VALUES) |-> hrdata[31:14] == 18'h0)
    else $error("translation reserved bits nonzero");

  ro_write_a: assert property (
    wr_pll_done |=> $stable({pll_f, pll_r}) && $stable(s.crystal_code))
    else $error("write changed translation register");

  table_match_a: assert property (
    s.loaded |-> {pll_f, pll_r} == ospt_pkg::crystal_code_to_pll(s.crystal_code))
    else $error("translation differs from lookup table");

  crystal_code_reset_a: assert property (
    $rose(s.loaded) |-> s.crystal_code == ospt_pkg::RST_CRYSTAL_CODE)
    else $error("crystal code not at reset value");

  // Write data phase of a whole word to the configuration register
  sequence wr_rcc_word;
    s.ph_act && s.ph_write && s.hreadyout && s.ph_word &&
      (s.ph_addr == ospt_pkg::OFS_RCC);
  endsequence

  // Read data phase while its single wait state is inserted
  sequence rd_wait;
    s.ph_act && !s.ph_write && !s.hreadyout;
  endsequence

  // A second wait state would stall every master on the bus
  rd_one_wait_a: assert property (
    rd_wait |=> hreadyout)
    else $error("read wait state longer than one cycle");

  wr_no_wait_a: assert property (
    s.ph_act && s.ph_write |-> hreadyout)
    else $error("write data phase stalled");

  src_write_a: assert property (
    wr_rcc_word |=> osc_source == $past(hwdata[5:4]))
    else $error("oscillator source not taken from write");

  internal_oscillator_write_a: assert property (
    wr_rcc_word |=> internal_osc_disable == $past(hwdata[1]))
    else $error("internal oscillator control not taken from write");

  main_oscillator_write_a: assert property (
    wr_rcc_word |=> main_osc_disable == $past(hwdata[0]))
    else $error("main oscillator control not taken from write");

  crystal_code_write_a: assert property (
    wr_rcc_word |=> s.crystal_code == $past(hwdata[9:6]))
    else $error("crystal code not taken from write");

  // Narrow writes are dropped rather than merged into the word
  narrow_wr_a: assert property (
    s.ph_act && s.ph_write && s.hreadyout && !s.ph_word |=>
      $stable(s.crystal_code) && $stable(osc_source) &&
      $stable(internal_osc_disable) && $stable(main_osc_disable))
    else $error("narrow write changed configuration");

  unmapped_rd_a: assert property (
    rd_wait and (s.ph_addr != ospt_pkg::OFS_RCC) and
      (s.ph_addr != ospt_pkg::OFS_PLL_TRANSLATION_VALUES) |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  no_early_a: assert property (
    !s.loaded |=> !s.ph_act)
    else $error("transfer accepted before translation loaded");

endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for oscillator select and PLL translation block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        ref_clk;
  logic        rstn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [1:0]  osc_source;
  logic        internal_osc_disable;
  logic        main_osc_disable;
  logic [8:0]  pll_f;
  logic [4:0]  pll_r;
  int          n_fail;
  int          checks_done;
  int          cycles;
  int          seed;
  logic [31:0] cfg_m;
  logic [31:0] rd;
  logic [31:0] d;
  // Model of the crystal table as handed over by the designer
  int          tab_f [16] = '{398, 215, 198, 161, 333, 323, 398, 388,
                              405, 398, 388, 398, 388, 378, 398, 388};
  int          tab_r [16] = '{0, 0, 0, 0, 2, 2, 3, 3, 4, 4, 4, 5, 5, 6, 7, 7};

  ospt_top u_ospt_top (
    .ref_clk              (ref_clk),
    .rstn                 (rstn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .osc_source           (osc_source),
    .internal_osc_disable (internal_osc_disable),
    .main_osc_disable     (main_osc_disable),
    .pll_f                (pll_f),
    .pll_r                (pll_r)
  );

  always #2.5 ref_clk = ~ref_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded by the timeout; a hang lands in the same closing report
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is looked at on the falling edge so the rising edge decides it
  task automatic wait_rdy();
    do @(negedge ref_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [2:0] sz, input logic [31:0] wd,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    wait_rdy();
    @(posedge ref_clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    @(posedge ref_clk);
  endtask

  task automatic chk_all();
    logic [31:0] pll_m;
    pll_m = {18'h0, tab_f[cfg_m[9:6]][8:0], tab_r[cfg_m[9:6]][4:0]};
    xfer(1'b0, ospt_pkg::OFS_RCC, ospt_pkg::HSIZE_WORD, 32'h0, rd);
    chk(rd, cfg_m);
    xfer(1'b0, ospt_pkg::OFS_PLL_TRANSLATION_VALUES, ospt_pkg::HSIZE_WORD, 32'h0, rd);
    chk(rd, pll_m);
    chk({30'h0, osc_source}, {30'h0, cfg_m[5:4]});
    chk({31'h0, internal_osc_disable}, {31'h0, cfg_m[1]});
    chk({31'h0, main_osc_disable}, {31'h0, cfg_m[0]});
    chk({23'h0, pll_f}, {23'h0, pll_m[13:5]});
    chk({27'h0, pll_r}, {27'h0, pll_m[4:0]});
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    seed = 32'hc544;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset image: main off, internal on, source internal, 6 MHz code
    cfg_m = 32'h0000_02d1;
    chk_all();
    for (int i = 0; i < 16; i++)
    begin
      d = $random(seed);
      d[9:6] = i[3:0];
      d[5:4] = i[1:0];
      d[1:0] = i[3:2];
      // Write then read back, bus idle in the write data phase; reserved and upper bits drop
      xfer(1'b1, ospt_pkg::OFS_RCC, ospt_pkg::HSIZE_WORD, d, rd);
      cfg_m = d & 32'h0000_03f3;
      chk_all();
      d = $random(seed);
      xfer(1'b1, ospt_pkg::OFS_PLL_TRANSLATION_VALUES, ospt_pkg::HSIZE_WORD, d, rd);
      chk_all();
    end
    // Byte-wide write is ignored by this slave
    xfer(1'b1, ospt_pkg::OFS_RCC, 3'h0, 32'h0000_0000, rd);
    chk_all();
    // Unmapped address reads zero
    xfer(1'b0, 12'h068, ospt_pkg::HSIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
